// *** rtl/dsr_regs.vh ***
// Purpose: constants for the disk adapter sense reporting block
// Assumes: included by bare name from design files
// Notes:   bit numbers are counted from the most significant bit of each byte
`ifndef DSR_REGS_VH
`define DSR_REGS_VH

// ----------------------------------------------------------------
// sense record layout
// ----------------------------------------------------------------
`define DSR_SENSE_BYTES       3'd6
`define DSR_IDX_CMD_ERR       3'd0
`define DSR_IDX_OP_ERR        3'd1
`define DSR_IDX_EQUIP         3'd2
`define DSR_IDX_LINES         3'd3
`define DSR_IDX_DRIVE         3'd4
`define DSR_IDX_OVFL          3'd5
`define DSR_SENSE_RESET       8'h00

// byte 0 bit positions (bit 0 is the msb, held at index 7)
`define DSR_B0_CMD_REJECT     7
`define DSR_B0_INTERVENTION   6
`define DSR_B0_BUS_PARITY     5
`define DSR_B0_EQUIP_CHECK    4
`define DSR_B0_DATA_CHECK     3
`define DSR_B0_OVERRUN        2
`define DSR_B0_TRACK_COND     1
`define DSR_B0_SEEK_CHECK     0

// byte 1 bit positions
`define DSR_B1_COUNT_CHECK    7
`define DSR_B1_TRACK_OVERRUN  6
`define DSR_B1_END_CYL        5
`define DSR_B1_INVALID_SEQ    4
`define DSR_B1_NO_RECORD      3
`define DSR_B1_FILE_PROTECT   2
`define DSR_B1_MISS_MARK      1
`define DSR_B1_OVFL_INC       0

// byte 2 bit positions; bits 1, 6 and 7 reserved
`define DSR_B2_UNSAFE         7
`define DSR_B2_SERDES         5
`define DSR_B2_SEL_STATUS     4
`define DSR_B2_CYCLIC         3
`define DSR_B2_UNSEL_STATUS   2
`define DSR_B2_USED_MASK      8'hBC

// byte 4 drive numbering
`define DSR_DRIVE_UNDEFINED   4'hF

// byte 5 interrupted command codes
`define DSR_OVF_NONE          3'd0
`define DSR_OVF_READ          3'd1
`define DSR_OVF_WRITE         3'd2
`define DSR_OVF_KD_EQ         3'd3
`define DSR_OVF_KD_HI         3'd4
`define DSR_OVF_KD_HIEQ       3'd5
`define DSR_OVF_KD_LOW        3'd6
`define DSR_OVF_KD_HIGH       3'd7
`define DSR_CODE_READ         8'h06
`define DSR_CODE_WRITE        8'h05
`define DSR_CODE_KD_EQ        8'h25
`define DSR_CODE_KD_HI        8'h45
`define DSR_CODE_KD_HIEQ      8'h65
`define DSR_CODE_KD_LOW       8'h55
`define DSR_CODE_KD_HIGH      8'h75

// ----------------------------------------------------------------
// command decode
// ----------------------------------------------------------------
`define DSR_CMD_SENSE         8'h04
`define DSR_CMD_NOOP          8'h03
`define DSR_CMD_RESTORE       8'h17
`define DSR_DEC_TEST          2'b00
`define DSR_DEC_WRITE         2'b01
`define DSR_DEC_READ          2'b10
`define DSR_DEC_CONTROL       2'b11

`endif

// *** rtl/dsr_byte_mux.v ***
// Purpose: selects one sense byte from the six-byte record by index
// Assumes: index beyond five reads as zero
// Notes:   combinational; caller registers the result
`timescale 1ns/100ps
`default_nettype none
`include "dsr_regs.vh"

module dsr_byte_mux (
    input  wire [47:0] record,
    input  wire [2:0]  index,
    output reg  [7:0]  byte_out
);

    // ----------------------------------------------------------------
    // byte select
    // ----------------------------------------------------------------
    // byte 0 sits in the top lane so the record reads left to right
    always @* begin
        case (index)
            3'd0:    byte_out = record[47:40];
            3'd1:    byte_out = record[39:32];
            3'd2:    byte_out = record[31:24];
            3'd3:    byte_out = record[23:16];
            3'd4:    byte_out = record[15:8];
            3'd5:    byte_out = record[7:0];
            default: byte_out = `DSR_SENSE_RESET;
        endcase
    end

endmodule
`default_nettype wire

// *** rtl/dsr_sense_unit.v ***
// Purpose: gathers the six-byte sense record and moves it out on a sense command
// Assumes: events are one-cycle pulses synchronous to mclk; storage accepts one
//          byte per cycle while st_ready is high
// Notes:   byte 3 and byte 4 are sampled live at transfer time
`timescale 1ns/100ps
`default_nettype none
`include "dsr_regs.vh"

// Summary of operation
// - a sense command stores up to six sense bytes from its data address
// - sense is posted only in the ending routine, never earlier
// - unit-check sense sets contingent connection; only same-module sense then accepted
// - any sense condition expanding status also raises unit check
// - outbound data parity error sets byte 0 bit 2
// - equipment check sets byte 0 bit 3 plus its byte 2 detail
// - data check sets byte 0 bit 4; count field adds byte 1 bit 0
// - late share-cycle or trap service sets byte 0 bit 5
// - defective track or alternate-track switch sets byte 0 bit 6
// - incomplete seek or head-compare failure sets byte 0 bit 7
// - write unfinished at index sets byte 1 bit 1
// - multi-track past last cylinder address sets byte 1 bit 2
// - invalid command sequence sets byte 1 bit 3 and byte 0 bit 0
// - two index passes sets byte 1 bit 4; missing home/record zero adds bit 6
// - equal sequence flags on successive counts set byte 1 bit 6
// - file mask violation sets byte 1 bit 5
// - stopped overflow sets byte 1 bit 7 and the byte 5 code; its cause bit comes on its own event line
// - byte 2 carries unsafe, serdes, selected, cyclic, unselected; rest reserved
// - byte 3 mirrors live selected drive interface lines
// - byte 4 low nibble is drive number, 1111 when no plug
// - byte 5 zero except overflow incomplete, then interrupted command code
// - decode from command bits 6 and 7; sense goes to control routine
// - active first command clears sense; no-op or restore keeps it
module dsr_sense_unit (
    input  wire        mclk,
    input  wire        rst_n,
    // command presentation
    input  wire        cmd_valid,
    input  wire [7:0]  cmd_code,
    input  wire        cmd_first,
    input  wire [2:0]  cmd_module,
    input  wire [15:0] cmd_count,
    input  wire        length_suppress_flag,
    input  wire [23:0] cmd_addr,

    // operation events, one-cycle pulses
    input  wire        ev_cmd_reject,
    input  wire        ev_intervention,
    input  wire        ev_bus_parity,
    input  wire        ev_data_check,
    input  wire        ev_count_field,
    input  wire        ev_clock_through,
    input  wire        ev_overrun,
    input  wire        ev_track_cond,
    input  wire        ev_seek_check,
    input  wire        ev_track_overrun,
    input  wire        ev_end_cyl,
    input  wire        ev_invalid_seq,
    input  wire        ev_no_record,
    input  wire        ev_miss_home,
    input  wire        ev_miss_mark,
    input  wire        ev_file_protect,
    input  wire        ev_ovfl_stop,
    input  wire [2:0]  ev_ovfl_kind,
    input  wire [7:0]  ev_equip_detail,
    input  wire        op_end,

    // drive side
    input  wire [7:0]  drive_lines,
    input  wire [3:0]  drive_plug,

    // outputs, with the st_ready input of the store handshake
    output reg         cmd_accept,
    output reg         cmd_refuse,
    output reg  [1:0]  cmd_decode,
    output reg         ctl_route,
    output reg         unit_check,
    output reg         contingent,
    output reg         st_valid,
    input  wire        st_ready,
    output reg  [23:0] st_addr,
    output reg  [7:0]  st_data,
    output reg         sense_done,
    output reg  [3:0]  block_check_appendix
);

    // ----------------------------------------------------------------
    // states and storage
    // ----------------------------------------------------------------
    localparam ST_IDLE = 1'b0;
    localparam ST_MOVE = 1'b1;

    reg        state;

    reg [7:0]  acc0;          // accumulating during the operation
    reg [7:0]  acc1;
    reg [7:0]  acc2;
    reg [7:0]  acc5;

    reg [7:0]  post0;         // posted copy read by sense
    reg [7:0]  post1;
    reg [7:0]  post2;
    reg [7:0]  post5;

    reg [2:0]  sel_module;
    reg [2:0]  byte_idx;
    reg [2:0]  byte_last;

    reg [7:0]  next_acc0;
    reg [7:0]  next_acc1;
    reg [7:0]  next_acc2;
    reg [7:0]  next_acc5;

    wire [7:0] mux_byte;
    wire       is_sense;
    wire       keep_old;
    wire       refuse_now;

    // command classes
    assign is_sense   = (cmd_code == `DSR_CMD_SENSE);
    assign keep_old   = (cmd_code == `DSR_CMD_NOOP) || (cmd_code == `DSR_CMD_RESTORE);
    // other modules locked out while contingent connection stands
    assign refuse_now = contingent && ((cmd_module != sel_module) || !is_sense);

    // ----------------------------------------------------------------
    // record byte selection
    // ----------------------------------------------------------------
    // bytes 3 and 4 are live, so the mux sees them unlatched
    dsr_byte_mux u_mux (
        .record   ({post0, post1, post2, drive_lines, 4'h0, drive_plug, post5}),
        .index    (byte_idx),
        .byte_out (mux_byte)
    );

    // ----------------------------------------------------------------
    // event accumulation
    // ----------------------------------------------------------------
    // sets are or-ed in after any clear so a same-cycle event survives
    always @* begin
        next_acc0 = acc0;
        next_acc1 = acc1;
        next_acc2 = acc2;
        next_acc5 = acc5;

        if (cmd_valid && state == ST_IDLE && !refuse_now && cmd_first && !keep_old
            && !is_sense) begin
            next_acc0 = `DSR_SENSE_RESET;
            next_acc1 = `DSR_SENSE_RESET;
            next_acc2 = `DSR_SENSE_RESET;
            next_acc5 = `DSR_SENSE_RESET;
        end

        // byte 0 faults
        if (ev_cmd_reject)
            next_acc0[`DSR_B0_CMD_REJECT] = 1'b1;

        if (ev_intervention)
            next_acc0[`DSR_B0_INTERVENTION] = 1'b1;

        if (ev_bus_parity)
            next_acc0[`DSR_B0_BUS_PARITY] = 1'b1;

        if (|(ev_equip_detail & `DSR_B2_USED_MASK)) begin
            next_acc0[`DSR_B0_EQUIP_CHECK] = 1'b1;
            next_acc2 = next_acc2 | (ev_equip_detail & `DSR_B2_USED_MASK);
        end

        // clock-through fields never flag a data check
        if (ev_data_check && !ev_clock_through) begin
            next_acc0[`DSR_B0_DATA_CHECK] = 1'b1;
            if (ev_count_field)
                next_acc1[`DSR_B1_COUNT_CHECK] = 1'b1;
        end

        if (ev_overrun)
            next_acc0[`DSR_B0_OVERRUN] = 1'b1;

        if (ev_track_cond)
            next_acc0[`DSR_B0_TRACK_COND] = 1'b1;

        if (ev_seek_check)
            next_acc0[`DSR_B0_SEEK_CHECK] = 1'b1;

        // byte 1 faults
        if (ev_track_overrun)
            next_acc1[`DSR_B1_TRACK_OVERRUN] = 1'b1;

        if (ev_end_cyl)
            next_acc1[`DSR_B1_END_CYL] = 1'b1;

        if (ev_invalid_seq) begin
            next_acc1[`DSR_B1_INVALID_SEQ] = 1'b1;
            next_acc0[`DSR_B0_CMD_REJECT] = 1'b1;
        end

        if (ev_no_record)
            next_acc1[`DSR_B1_NO_RECORD] = 1'b1;

        // both bits
        if (ev_miss_home) begin
            next_acc1[`DSR_B1_NO_RECORD] = 1'b1;
            next_acc1[`DSR_B1_MISS_MARK] = 1'b1;
        end

        if (ev_miss_mark)
            next_acc1[`DSR_B1_MISS_MARK] = 1'b1;

        if (ev_file_protect)
            next_acc1[`DSR_B1_FILE_PROTECT] = 1'b1;

        // overflow stop: cause bits arrive on their own event lines
        if (ev_ovfl_stop) begin
            next_acc1[`DSR_B1_OVFL_INC] = 1'b1;
            case (ev_ovfl_kind)
                `DSR_OVF_READ:    next_acc5 = `DSR_CODE_READ;
                `DSR_OVF_WRITE:   next_acc5 = `DSR_CODE_WRITE;
                `DSR_OVF_KD_EQ:   next_acc5 = `DSR_CODE_KD_EQ;
                `DSR_OVF_KD_HI:   next_acc5 = `DSR_CODE_KD_HI;
                `DSR_OVF_KD_HIEQ: next_acc5 = `DSR_CODE_KD_HIEQ;
                `DSR_OVF_KD_LOW:  next_acc5 = `DSR_CODE_KD_LOW;
                `DSR_OVF_KD_HIGH: next_acc5 = `DSR_CODE_KD_HIGH;
                default:          next_acc5 = `DSR_SENSE_RESET;
            endcase
        end
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            acc0 <= `DSR_SENSE_RESET;
            acc1 <= `DSR_SENSE_RESET;
            acc2 <= `DSR_SENSE_RESET;
            acc5 <= `DSR_SENSE_RESET;
        end else begin
            acc0 <= next_acc0;
            acc1 <= next_acc1;
            acc2 <= next_acc2;
            acc5 <= next_acc5;
        end
    end

    // ----------------------------------------------------------------
    // posting at the ending routine
    // ----------------------------------------------------------------
    // the posted copy moves only on op_end so a sense never sees half an operation
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            post0      <= `DSR_SENSE_RESET;
            post1      <= `DSR_SENSE_RESET;
            post2      <= `DSR_SENSE_RESET;
            post5      <= `DSR_SENSE_RESET;
            unit_check <= 1'b0;
            contingent <= 1'b0;
        end else begin
            if (op_end) begin
                post0      <= next_acc0;
                post1      <= next_acc1;
                post2      <= next_acc2;
                post5      <= next_acc5;

                unit_check <= (|next_acc0) || (|next_acc1) || (|next_acc2);
                contingent <= (|next_acc0) || (|next_acc1) || (|next_acc2);
            end else if (sense_done) begin
                // a completed sense releases the connection; new posting would win
                contingent <= 1'b0;
                unit_check <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // command decode and sense transfer
    // ----------------------------------------------------------------
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state                <= ST_IDLE;
            cmd_accept           <= 1'b0;
            cmd_refuse           <= 1'b0;
            cmd_decode           <= `DSR_DEC_TEST;
            ctl_route            <= 1'b0;
            sel_module           <= 3'd0;
            byte_idx             <= 3'd0;
            byte_last            <= 3'd0;
            st_valid             <= 1'b0;
            st_addr              <= 24'h000000;
            st_data              <= 8'h00;
            sense_done           <= 1'b0;
            block_check_appendix <= `DSR_DRIVE_UNDEFINED;
        end else begin
            // pulses drop unless set
            cmd_accept           <= 1'b0;
            cmd_refuse           <= 1'b0;
            ctl_route            <= 1'b0;
            sense_done           <= 1'b0;
            block_check_appendix <= drive_plug;

            case (state)
                ST_IDLE: begin
                    if (cmd_valid) begin
                        cmd_decode <= cmd_code[1:0];
                        if (refuse_now) begin
                            cmd_refuse <= 1'b1;
                        end else begin
                            cmd_accept <= 1'b1;
                            sel_module <= cmd_module;
                            if (is_sense && cmd_count != 16'h0000) begin
                                // nonzero counts other than six go ahead; length_suppress_flag is never examined
                                ctl_route <= 1'b1;
                                state     <= ST_MOVE;
                                byte_idx  <= 3'd0;
                                st_addr   <= cmd_addr;
                                // short counts trim, long counts stop at six
                                if (cmd_count < 16'h0006)
                                    byte_last <= cmd_count[2:0] - 3'd1;
                                else
                                    byte_last <= `DSR_SENSE_BYTES - 3'd1;
                            end
                        end
                    end
                end
                ST_MOVE: begin
                    // held until taken
                    if (!st_valid) begin
                        st_valid <= 1'b1;
                        st_data  <= mux_byte;
                    end else if (st_ready) begin
                        if (byte_idx == byte_last) begin
                            st_valid   <= 1'b0;
                            sense_done <= 1'b1;
                            state      <= ST_IDLE;
                        end else begin
                            byte_idx <= byte_idx + 3'd1;
                            st_addr  <= st_addr + 24'h000001;
                            st_valid <= 1'b0;
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

endmodule
`default_nettype wire

// *** bench/dsr_sense_sva.sv ***
// Purpose: port-level assertions for the sense unit
// Assumes: one mclk domain, rst_n asynchronous active low
// Notes:   bound into every dsr_sense_unit instance
`timescale 1ns/100ps
`default_nettype none
`include "dsr_regs.vh"

module dsr_sense_sva (
    input wire logic        mclk, rst_n, cmd_valid, op_end, st_ready,
    input wire logic [7:0]  cmd_code,
    input wire logic [3:0]  drive_plug, block_check_appendix,
    input wire logic        cmd_accept, cmd_refuse, ctl_route, unit_check,
    input wire logic        contingent, st_valid, sense_done,
    input wire logic [1:0]  cmd_decode,
    input wire logic [23:0] st_addr,
    input wire logic [7:0]  st_data
);
    // low code bits kept as a signal so $past sees a plain name
    wire logic [1:0] code_low = cmd_code[1:0];

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // ----------------------------------------------------------------
    // command answer
    // ----------------------------------------------------------------
    a_answer_once: assert property (!(cmd_accept && cmd_refuse))
        else $error("accept and refuse together");
    a_decode_taken: assert property (cmd_accept |-> cmd_decode == $past(code_low))
        else $error("decode not from command bits");
    a_route_sense: assert property (ctl_route |-> cmd_accept && $past(cmd_code) == `DSR_CMD_SENSE)
        else $error("control route without sense");
    a_refuse_cause: assert property (cmd_refuse |-> $past(contingent))
        else $error("refusal without contingent connection");
    a_lock_sense: assert property (cmd_accept && $past(contingent) |-> $past(cmd_code) == `DSR_CMD_SENSE)
        else $error("non-sense accepted while contingent");
    // ----------------------------------------------------------------
    // posting and store side
    // ----------------------------------------------------------------
    a_unit_pair: assert property (unit_check == contingent)
        else $error("unit check and contingent differ");
    a_post_end: assert property ($rose(unit_check) |-> $past(op_end))
        else $error("unit check raised outside ending");
    a_done_clears: assert property (sense_done |=> !unit_check)
        else $error("unit check survives sense");
    a_store_hold: assert property (st_valid && !st_ready |=> st_valid && $stable(st_addr) && $stable(st_data))
        else $error("store request changed before taken");
    a_addr_step: assert property (st_valid && st_ready ##1 !st_valid ##1 st_valid |-> st_addr == $past(st_addr, 2) + 24'h000001)
        else $error("store address not consecutive");
    a_plug_copy: assert property ($past(rst_n) |-> block_check_appendix == $past(drive_plug))
        else $error("appendix nibble not drive number");

    c_done: cover property (sense_done);
    c_refuse: cover property (cmd_refuse);
    c_stall: cover property (st_valid && !st_ready);
endmodule

bind dsr_sense_unit dsr_sense_sva u_sva (
    .mclk(mclk), .rst_n(rst_n), .cmd_valid(cmd_valid), .op_end(op_end), .st_ready(st_ready),
    .cmd_code(cmd_code), .drive_plug(drive_plug), .block_check_appendix(block_check_appendix),
    .cmd_accept(cmd_accept), .cmd_refuse(cmd_refuse), .ctl_route(ctl_route),
    .unit_check(unit_check), .contingent(contingent), .st_valid(st_valid),
    .sense_done(sense_done), .cmd_decode(cmd_decode), .st_addr(st_addr), .st_data(st_data)
);
`default_nettype wire

// *** bench/dsr_store_model.sv ***
// Purpose: main storage side taking sense bytes
// Assumes: one byte per taken cycle
// Notes:   slow mode grants ready one cycle in four
`timescale 1ns/100ps
`default_nettype none

module dsr_store_model (
    input  wire logic        mclk, rst_n, slow, clr, st_valid,
    input  wire logic [23:0] st_addr,
    input  wire logic [7:0]  st_data,
    output var  logic        st_ready
);
    logic [1:0]  pace;
    logic [7:0]  mem [0:7];
    logic [23:0] adr [0:7];
    int          cnt;

    // ready pacing and byte capture, changed only after the edge
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pace <= 2'h0;
            st_ready <= 1'b0;
            cnt <= 0;
        end else begin
            pace <= pace + 2'h1;
            st_ready <= !slow || (pace == 2'h2);
            if (clr)
                cnt <= 0;
            else if (st_valid && st_ready) begin
                mem[cnt[2:0]] <= st_data;
                adr[cnt[2:0]] <= st_addr;
                cnt <= cnt + 1;
            end
        end
    end
endmodule
`default_nettype wire

// *** bench/tb.sv ***
// Purpose: self-checking bench for the sense unit
// Assumes: inputs change at the falling edge
// Notes:   expected records are built from the bit layout
`timescale 1ns/100ps
`default_nettype none
`include "dsr_regs.vh"

module tb;
    logic        mclk, rst_n, cmd_valid, cmd_first, lsf, op_end, slow, clr;
    logic [7:0]  cmd_code, drive_lines, equip;
    logic [2:0]  cmd_module, okind;
    logic [15:0] cmd_count;
    logic [23:0] cmd_addr, st_addr;
    logic [16:0] ev;
    logic [3:0]  drive_plug, appendix;
    logic [1:0]  cmd_decode;
    logic [7:0]  st_data;
    logic        cmd_accept, cmd_refuse, ctl_route, unit_check, contingent;
    logic        st_valid, st_ready, sense_done;
    int          bad_count, checked;

    dsr_sense_unit uut (.mclk(mclk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_first(cmd_first), .cmd_module(cmd_module), .cmd_count(cmd_count),
        .length_suppress_flag(lsf), .cmd_addr(cmd_addr), .ev_cmd_reject(ev[0]),
        .ev_intervention(ev[1]), .ev_bus_parity(ev[2]), .ev_data_check(ev[3]),
        .ev_count_field(ev[4]), .ev_clock_through(ev[5]), .ev_overrun(ev[6]),
        .ev_track_cond(ev[7]), .ev_seek_check(ev[8]), .ev_track_overrun(ev[9]),
        .ev_end_cyl(ev[10]), .ev_invalid_seq(ev[11]), .ev_no_record(ev[12]),
        .ev_miss_home(ev[13]), .ev_miss_mark(ev[14]), .ev_file_protect(ev[15]),
        .ev_ovfl_stop(ev[16]), .ev_ovfl_kind(okind), .ev_equip_detail(equip), .op_end(op_end),
        .drive_lines(drive_lines), .drive_plug(drive_plug), .cmd_accept(cmd_accept),
        .cmd_refuse(cmd_refuse), .cmd_decode(cmd_decode), .ctl_route(ctl_route),
        .unit_check(unit_check), .contingent(contingent), .st_valid(st_valid),
        .st_ready(st_ready), .st_addr(st_addr), .st_data(st_data), .sense_done(sense_done),
        .block_check_appendix(appendix));
    dsr_store_model model (.mclk(mclk), .rst_n(rst_n), .slow(slow), .clr(clr),
        .st_valid(st_valid), .st_addr(st_addr), .st_data(st_data), .st_ready(st_ready));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    // one-cycle command pulse; answer read one cycle later
    task automatic issue(input logic [7:0] code, input logic [2:0] md, input logic first,
                         output logic ok);
        @(negedge mclk);
        cmd_code = code;
        cmd_module = md;
        cmd_count = 16'h0000;
        cmd_first = first;
        cmd_valid = 1'b1;
        @(negedge mclk);
        cmd_valid = 1'b0;
        ok = cmd_accept;
    endtask

    // events in one cycle, ending routine in the next
    task automatic post(input logic [16:0] e, input logic [2:0] k, input logic [7:0] q);
        ev = e;
        okind = k;
        equip = q;
        @(negedge mclk);
        ev = 17'h00000;
        equip = 8'h00;
        op_end = 1'b1;
        @(negedge mclk);
        op_end = 1'b0;
        @(negedge mclk);
    endtask

    // sense of n bytes; stored bytes and addresses judged from the model
    task automatic sense(input logic [2:0] md, input logic [15:0] n, input logic [47:0] rec);
        logic ok;
        int   i;
        clr = 1'b1;
        @(negedge mclk);
        clr = 1'b0;
        lsf = (n != 16'h0006);
        cmd_code = `DSR_CMD_SENSE;
        cmd_module = md;
        cmd_count = n;
        cmd_first = 1'b0;
        cmd_valid = 1'b1;
        @(negedge mclk);
        cmd_valid = 1'b0;
        check(cmd_accept, 24'h1);
        check(ctl_route, 24'h1);
        i = 0;
        while (!sense_done && i < 200) begin
            @(negedge mclk);
            i++;
        end
        check(sense_done, 24'h1);
        check(24'(model.cnt), 24'(n));
        for (i = 0; i < n; i++) begin
            check(model.mem[i], rec[47 - 8 * i -: 8]);
            check(model.adr[i], cmd_addr + 24'(i));
        end
        @(negedge mclk);
        check(unit_check, 24'h0);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        check(appendix, 24'h5);
        check({cmd_accept, unit_check, st_valid, sense_done}, 24'h0);
    endtask

    task automatic t_full;
        logic ok;
        slow = 1'b1;
        issue(8'h06, 3'd2, 1'b1, ok);
        check(ok, 24'h1);
        check(cmd_decode, 24'h2);
        post(17'h0281C, 3'd0, 8'h00);
        check({unit_check, contingent}, 24'h3);
        issue(8'h06, 3'd2, 1'b1, ok);
        check({ok, cmd_refuse}, 24'h1);
        issue(`DSR_CMD_SENSE, 3'd5, 1'b0, ok);
        check({ok, cmd_refuse}, 24'h1);
        sense(3'd2, 16'h0006, {8'hA8, 8'h9A, 8'h00, 8'hC5, 8'h05, 8'h00});
        slow = 1'b0;
    endtask

    // clock-through hides data check; active first command clears old record
    task automatic t_clock;
        logic ok;
        drive_plug = 4'hF;
        issue(8'h06, 3'd1, 1'b1, ok);
        post(17'h0D76B, 3'd0, 8'h00);
        check(appendix, 24'hF);
        sense(3'd1, 16'h0006, {8'hC5, 8'h6E, 8'h00, 8'hC5, 8'h0F, 8'h00});
        drive_plug = 4'h5;
    endtask

    task automatic t_ovfl;
        logic       ok;
        logic [7:0] codes [1:7];
        logic [7:0] q;
        logic [47:0] rec;
        codes = '{8'h06, 8'h05, 8'h25, 8'h45, 8'h65, 8'h55, 8'h75};
        cmd_addr = 24'h00FFFE;
        for (int k = 1; k < 8; k++) begin
            q = (k == 1) ? 8'hBC : 8'h00;
            issue(8'h05, 3'd3, 1'b1, ok);
            check(cmd_decode, 24'h1);
            post(17'h10080, 3'(k), q);
            rec = {(k == 1) ? 8'h12 : 8'h02, 8'h01, q, 8'hC5, 8'h05, codes[k]};
            sense(3'd3, 16'h0006, rec);
        end
        // no-op and restore keep the posted record
        issue(`DSR_CMD_NOOP, 3'd3, 1'b1, ok);
        post(17'h00000, 3'd0, 8'h00);
        sense(3'd3, 16'h0006, rec);
        issue(`DSR_CMD_RESTORE, 3'd3, 1'b1, ok);
        post(17'h00000, 3'd0, 8'h00);
        sense(3'd3, 16'h0003, rec);
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // clock, sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    initial begin
        {rst_n, cmd_valid, cmd_first, lsf, op_end, slow, clr} = 7'h00;
        {cmd_code, equip, cmd_module, okind, cmd_count, ev} = '0;
        drive_lines = 8'hC5;
        drive_plug = 4'h5;
        cmd_addr = 24'h001000;
        bad_count = 0;
        checked = 0;
        repeat (5) @(negedge mclk);
        rst_n = 1'b1;
        repeat (2) @(negedge mclk);
        t_reset;
        t_full;
        t_clock;
        t_ovfl;
        complete_run;
    end

    // whole run needs well under a thousand cycles
    initial begin
        #(40 * 5000);
        bad_count++;
        complete_run;
    end
endmodule
`default_nettype wire
